// ### verilog/lpm_pkg.sv
// =============================================================================
// Shared constants and types of the low-power mode controller.
package lpm_pkg;

    // =========================================================================
    // Register map: word index on the plain register port.
    localparam int unsigned ADDR_WIDTH = 2;
    localparam logic [1:0] ADDR_STANDBY_CTRL = 2'h0;
    localparam logic [1:0] ADDR_SPEED_CTRL   = 2'h1;
    localparam logic [1:0] ADDR_MODE_STATUS  = 2'h2;

    // =========================================================================
    // Field positions of the standby mode control register.
    localparam int unsigned POS_SW_STANDBY = 7;
    localparam int unsigned POS_WAIT_SEL   = 4;
    localparam int unsigned POS_LOW_SPEED  = 3;

    // Field positions of the clock speed control register.
    localparam int unsigned POS_NOISE_RATE = 4;
    localparam int unsigned POS_DIRECT_TX  = 3;
    localparam int unsigned POS_MEDIUM_SPD = 2;
    localparam int unsigned POS_SUB_DIV    = 0;

    // Unused bits of both control registers read as one.
    localparam logic [7:0] STANDBY_FILL = 8'h07;
    localparam logic [7:0] SPEED_FILL   = 8'he0;

    // =========================================================================
    // Settling wait in states, one state being one clock cycle.
    localparam int unsigned WAIT_CODE0_STATES = 8192;
    localparam int unsigned WAIT_CODE1_STATES = 16384;
    localparam int unsigned WAIT_CODE2_STATES = 32768;
    localparam int unsigned WAIT_CODE3_STATES = 65536;
    localparam int unsigned WAIT_CODE4_STATES = 131072;
    localparam int unsigned WAIT_CNT_WIDTH    = 18;

    // Noise filter sample divider ratios of the oscillator clock.
    localparam logic [4:0] NOISE_DIV_SLOW = 5'h10;
    localparam logic [4:0] NOISE_DIV_FAST = 5'h04;

    // Pin synchroniser reset level.
    localparam logic SYNC_RESET_LEVEL = 1'b0;

    // =========================================================================
    // Operating modes of the CPU clock domain.
    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'b000,
        MODE_SUBACTIVE = 3'b001,
        MODE_SLEEP     = 3'b010,
        MODE_SUBSLEEP  = 3'b011,
        MODE_STANDBY   = 3'b100,
        MODE_WATCH     = 3'b101,
        MODE_SETTLE    = 3'b110
    } mode_type;

    // Writable fields of the standby mode control register.
    typedef struct packed {
        logic       sw_standby;
        logic [2:0] wait_sel;
        logic       low_speed;
    } standby_ctrl_type;

    // Writable fields of the clock speed control register.
    typedef struct packed {
        logic       noise_rate_sel;
        logic       direct_transfer_on;
        logic       medium_speed_select;
        logic [1:0] sub_clock_div;
    } speed_ctrl_type;

    localparam standby_ctrl_type STANDBY_CTRL_RESET = '{1'b0, 3'h0, 1'b0};
    localparam speed_ctrl_type   SPEED_CTRL_RESET   = '{1'b0, 1'b0, 1'b0, 2'h0};

endpackage

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
// =============================================================================
// Three-stage pin synchroniser; the output follows once stages two and three agree.
module pin_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic agree;

    // Stages two and three agreeing marks a settled pin level.
    assign agree = (stage2 == stage3);

    // Shift the pin through three flip-flops and hold the settled level.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1  <= lpm_pkg::SYNC_RESET_LEVEL;
            stage2  <= lpm_pkg::SYNC_RESET_LEVEL;
            stage3  <= lpm_pkg::SYNC_RESET_LEVEL;
            level_o <= lpm_pkg::SYNC_RESET_LEVEL;
        end else begin
            stage1  <= pin_i;
            stage2  <= stage1;
            stage3  <= stage2;
            level_o <= agree ? stage3 : level_o;
        end
    end
endmodule

// ### verilog/low_power_mode_control.sv
`timescale 1ns/1ps
// =============================================================================
// Operation
// - Low-speed select 0 clocks the CPU from system clock, 1 from subclock.
// - Wait field picks 8192, 16384, 32768, 65536 states; top bit set picks 131072.
// - Standby bit clear: sleep in active enters sleep, in subactive enters subsleep.
// - Standby bit set: sleep in active enters standby or watch, subactive enters watch.
// - Noise filter samples at oscillator clock over 16 when select 0, over 4 when 1.
module low_power_mode_control #(
    parameter int unsigned WAIT0 = lpm_pkg::WAIT_CODE0_STATES,
    parameter int unsigned WAIT1 = lpm_pkg::WAIT_CODE1_STATES,
    parameter int unsigned WAIT2 = lpm_pkg::WAIT_CODE2_STATES,
    parameter int unsigned WAIT3 = lpm_pkg::WAIT_CODE3_STATES,
    parameter int unsigned WAIT4 = lpm_pkg::WAIT_CODE4_STATES
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_n_i,
    input  wire logic [lpm_pkg::ADDR_WIDTH-1:0]  addr_i,
    input  wire logic [7:0]                      wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [7:0]                      rdata_o,
    input  wire logic                            sleep_exec_i,
    input  wire logic                            watch_clock_on_i,
    input  wire logic                            wake_pin_i,
    output logic                                 cpu_clk_sub_o,
    output logic                                 cpu_stop_o,
    output logic                                 clocks_off_o,
    output logic      [2:0]                      mode_o,
    output logic                                 noise_sample_tick_o,
    output logic                                 direct_transfer_on_o,
    output logic                                 medium_speed_select_o,
    output logic      [1:0]                      sub_clock_div_o
);
    localparam int unsigned CW = lpm_pkg::WAIT_CNT_WIDTH;

    // =========================================================================
    // Reset release and pin synchronisation.
    logic rst_meta;
    logic rst_n;
    logic wake_level;

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    pin_sync wake_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .pin_i   (wake_pin_i),
        .level_o (wake_level)
    );

    // =========================================================================
    // Register port decode and storage.
    lpm_pkg::standby_ctrl_type standby_ctrl;
    lpm_pkg::speed_ctrl_type   speed_ctrl;
    lpm_pkg::mode_type         mode;
    lpm_pkg::mode_type         next_mode;
    logic                      wr_standby;
    logic                      wr_speed;
    logic [7:0]                standby_view;
    logic [7:0]                speed_view;
    logic [7:0]                status_view;
    logic [7:0]                next_rdata;

    // Write strobe decode for each control register.
    assign wr_standby = wr_i && (addr_i == lpm_pkg::ADDR_STANDBY_CTRL);
    assign wr_speed   = wr_i && (addr_i == lpm_pkg::ADDR_SPEED_CTRL);

    // Read views; unused control register bits read as one, the status register shows the mode.
    assign standby_view = {standby_ctrl, 3'h0} | lpm_pkg::STANDBY_FILL;
    assign speed_view   = {3'h0, speed_ctrl} | lpm_pkg::SPEED_FILL;
    assign status_view  = {5'h00, mode};
    assign next_rdata   = !rd_i                                   ? 8'h00 :
                          (addr_i == lpm_pkg::ADDR_STANDBY_CTRL) ? standby_view :
                          (addr_i == lpm_pkg::ADDR_SPEED_CTRL)   ? speed_view :
                          (addr_i == lpm_pkg::ADDR_MODE_STATUS)  ? status_view : 8'h00;

    // Control registers take writes; read data stands only in the cycle after a read.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_ctrl <= lpm_pkg::STANDBY_CTRL_RESET;
            speed_ctrl   <= lpm_pkg::SPEED_CTRL_RESET;
            rdata_o      <= 8'h00;
        end else begin
            standby_ctrl <= wr_standby ? lpm_pkg::standby_ctrl_type'(wdata_i[7:3]) : standby_ctrl;
            speed_ctrl   <= wr_speed ? lpm_pkg::speed_ctrl_type'(wdata_i[4:0]) : speed_ctrl;
            rdata_o      <= next_rdata;
        end
    end

    // =========================================================================
    // Settling wait length chosen by the wait field.
    logic [CW-1:0] wait_target;

    // Any code with the top bit set gives the longest wait.
    assign wait_target = standby_ctrl.wait_sel[2]          ? CW'(WAIT4) :
                         (standby_ctrl.wait_sel[1:0] == 2'h0) ? CW'(WAIT0) :
                         (standby_ctrl.wait_sel[1:0] == 2'h1) ? CW'(WAIT1) :
                         (standby_ctrl.wait_sel[1:0] == 2'h2) ? CW'(WAIT2) : CW'(WAIT3);

    // =========================================================================
    // Mode sequencer.
    logic [CW-1:0] settle_cnt;
    logic [CW-1:0] next_settle_cnt;
    logic          settle_done;
    logic          run_mode;

    assign settle_done = (settle_cnt == {CW{1'b0}});
    assign run_mode    = (mode == lpm_pkg::MODE_ACTIVE) || (mode == lpm_pkg::MODE_SUBACTIVE);

    // Next mode from the sleep instruction, the wake pin and the settling counter.
    always_comb begin
        next_mode       = mode;
        next_settle_cnt = (settle_cnt == {CW{1'b0}}) ? settle_cnt : settle_cnt - CW'(1);
        unique case (mode)
            lpm_pkg::MODE_ACTIVE: begin
                if (sleep_exec_i && !standby_ctrl.sw_standby) begin
                    next_mode = lpm_pkg::MODE_SLEEP;
                end else if (sleep_exec_i) begin
                    next_mode = watch_clock_on_i ? lpm_pkg::MODE_WATCH : lpm_pkg::MODE_STANDBY;
                end else if (standby_ctrl.low_speed) begin
                    next_mode = lpm_pkg::MODE_SUBACTIVE;
                end
            end
            lpm_pkg::MODE_SUBACTIVE: begin
                if (sleep_exec_i && !standby_ctrl.sw_standby) begin
                    next_mode = lpm_pkg::MODE_SUBSLEEP;
                end else if (sleep_exec_i) begin
                    next_mode = lpm_pkg::MODE_WATCH;
                end else if (!standby_ctrl.low_speed) begin
                    next_mode = lpm_pkg::MODE_ACTIVE;
                end
            end
            lpm_pkg::MODE_SLEEP: begin
                if (wake_level) begin
                    next_mode = lpm_pkg::MODE_ACTIVE;
                end
            end
            lpm_pkg::MODE_SUBSLEEP: begin
                if (wake_level) begin
                    next_mode = lpm_pkg::MODE_SUBACTIVE;
                end
            end
            lpm_pkg::MODE_STANDBY, lpm_pkg::MODE_WATCH: begin
                if (wake_level) begin
                    next_mode       = lpm_pkg::MODE_SETTLE;
                    next_settle_cnt = wait_target - CW'(1);
                end
            end
            lpm_pkg::MODE_SETTLE: begin
                if (settle_done) begin
                    next_mode = standby_ctrl.low_speed ? lpm_pkg::MODE_SUBACTIVE : lpm_pkg::MODE_ACTIVE;
                end
            end
            default: begin
                next_mode = lpm_pkg::MODE_ACTIVE;
            end
        endcase
    end

    // Mode and settling counter registers.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= lpm_pkg::MODE_ACTIVE;
            settle_cnt <= {CW{1'b0}};
        end else begin
            mode       <= next_mode;
            settle_cnt <= next_settle_cnt;
        end
    end

    // =========================================================================
    // Noise filter sample tick.
    logic [4:0] noise_cnt;
    logic [4:0] noise_div;
    logic       noise_wrap;
    logic       rate_prev;
    logic       rate_change;

    assign noise_div   = speed_ctrl.noise_rate_sel ? lpm_pkg::NOISE_DIV_FAST : lpm_pkg::NOISE_DIV_SLOW;
    assign noise_wrap  = (noise_cnt == noise_div - 5'h01);
    assign rate_change = (rate_prev != speed_ctrl.noise_rate_sel);

    // The divider restarts when the rate changes so no stretched period appears.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            noise_cnt           <= 5'h00;
            rate_prev           <= 1'b0;
            noise_sample_tick_o <= 1'b0;
        end else begin
            noise_cnt           <= (noise_wrap || rate_change) ? 5'h00 : noise_cnt + 5'h01;
            rate_prev           <= speed_ctrl.noise_rate_sel;
            noise_sample_tick_o <= noise_wrap && !rate_change;
        end
    end

    // =========================================================================
    // Registered outputs.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_sub_o         <= 1'b0;
            cpu_stop_o            <= 1'b0;
            clocks_off_o          <= 1'b0;
            mode_o                <= 3'h0;
            direct_transfer_on_o  <= 1'b0;
            medium_speed_select_o <= 1'b0;
            sub_clock_div_o       <= 2'h0;
        end else begin
            cpu_clk_sub_o         <= standby_ctrl.low_speed;
            cpu_stop_o            <= !((next_mode == lpm_pkg::MODE_ACTIVE)
                                       || (next_mode == lpm_pkg::MODE_SUBACTIVE));
            clocks_off_o          <= (next_mode == lpm_pkg::MODE_STANDBY)
                                     || (next_mode == lpm_pkg::MODE_WATCH);
            mode_o                <= next_mode;
            direct_transfer_on_o  <= speed_ctrl.direct_transfer_on;
            medium_speed_select_o <= speed_ctrl.medium_speed_select;
            sub_clock_div_o       <= speed_ctrl.sub_clock_div;
        end
    end

    // =========================================================================
    // Checking helpers and assertions.
    logic [CW-1:0] settle_seen;
    logic [5:0]    tick_gap;
    logic          gap_valid;

    // Count cycles spent settling and cycles between sample ticks.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            settle_seen <= {CW{1'b0}};
            tick_gap    <= 6'h00;
            gap_valid   <= 1'b0;
        end else begin
            settle_seen <= (mode == lpm_pkg::MODE_SETTLE) ? settle_seen + CW'(1) : {CW{1'b0}};
            tick_gap    <= noise_sample_tick_o ? 6'h01 : tick_gap + 6'h01;
            gap_valid   <= rate_change ? 1'b0 : (noise_sample_tick_o ? 1'b1 : gap_valid);
        end
    end

    sequence seq_sleep_request(logic standby_bit, lpm_pkg::mode_type from_mode);
        sleep_exec_i && (standby_ctrl.sw_standby == standby_bit) && (mode == from_mode);
    endsequence

    sequence seq_wake_from_stop;
        ((mode == lpm_pkg::MODE_STANDBY) || (mode == lpm_pkg::MODE_WATCH)) && wake_level;
    endsequence

    chk_clock_select: assert property (@(posedge clk_i) disable iff (!rst_n)
        wr_standby |=> ##1 (cpu_clk_sub_o == $past(wdata_i[3], 2)))
        else $error("CPU clock select does not follow the low-speed bit.");

    chk_sleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
        seq_sleep_request(1'b0, lpm_pkg::MODE_ACTIVE) |=> (mode == lpm_pkg::MODE_SLEEP) && cpu_stop_o)
        else $error("Sleep instruction in active mode did not enter sleep.");

    chk_subsleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
        seq_sleep_request(1'b0, lpm_pkg::MODE_SUBACTIVE) |=> (mode == lpm_pkg::MODE_SUBSLEEP))
        else $error("Sleep instruction in subactive mode did not enter subsleep.");

    chk_standby_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
        seq_sleep_request(1'b1, lpm_pkg::MODE_ACTIVE)
        |=> (mode == ($past(watch_clock_on_i) ? lpm_pkg::MODE_WATCH : lpm_pkg::MODE_STANDBY)) && clocks_off_o)
        else $error("Sleep instruction with standby set did not enter standby or watch.");

    chk_watch_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
        seq_sleep_request(1'b1, lpm_pkg::MODE_SUBACTIVE) |=> (mode == lpm_pkg::MODE_WATCH))
        else $error("Sleep instruction in subactive mode did not enter watch.");

    chk_noise_period: assert property (@(posedge clk_i) disable iff (!rst_n)
        (noise_sample_tick_o && gap_valid && !rate_change && !$past(rate_change))
        |-> (tick_gap == (speed_ctrl.noise_rate_sel ? 6'h04 : 6'h10)))
        else $error("Noise sample tick period is wrong.");

    chk_wait_length: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((mode == lpm_pkg::MODE_SETTLE) && settle_done) |-> (settle_seen == wait_target - CW'(1)))
        else $error("Settling wait does not match the selected count.");

    chk_settle_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
        seq_wake_from_stop |=> (mode == lpm_pkg::MODE_SETTLE) ##1 cpu_stop_o)
        else $error("CPU not held stopped after leaving standby or watch.");

    chk_read_data: assert property (@(posedge clk_i) disable iff (!rst_n)
        (rd_i && (addr_i == lpm_pkg::ADDR_STANDBY_CTRL) && !wr_i)
        |=> (rdata_o == standby_view) ##1 ($past(rd_i) || (rdata_o == 8'h00)))
        else $error("Register read data wrong or held too long.");

    chk_sub_switch: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((mode == lpm_pkg::MODE_ACTIVE) && standby_ctrl.low_speed && !sleep_exec_i)
        |=> (mode == lpm_pkg::MODE_SUBACTIVE))
        else $error("Low-speed select did not move the CPU to the subclock mode.");

    chk_settle_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
        (mode == lpm_pkg::MODE_SETTLE) |-> cpu_stop_o && !clocks_off_o && (mode_o == lpm_pkg::MODE_SETTLE))
        else $error("CPU not held stopped with clocks running while settling.");

    chk_sleep_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((mode == lpm_pkg::MODE_SLEEP) && wake_level) |=> (mode == lpm_pkg::MODE_ACTIVE) && !cpu_stop_o)
        else $error("Wake from sleep did not return to active mode.");

endmodule

// ### verification/low_power_mode_control_tb.sv
`timescale 1ns/1ps
// =============================================================================
// Self-checking bench: register port tasks and sleep/wake sequences.
module low_power_mode_control_tb;
    localparam int unsigned W0 = 8;
    localparam int unsigned W1 = 12;
    localparam int unsigned W2 = 16;
    localparam int unsigned W3 = 20;
    localparam int unsigned W4 = 24;

    logic       clk_i, rst_n_i, wr_i, rd_i, sleep_exec_i, watch_clock_on_i, wake_pin_i;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic       cpu_clk_sub_o, cpu_stop_o, clocks_off_o, noise_sample_tick_o;
    logic       direct_transfer_on_o, medium_speed_select_o;
    logic [2:0] mode_o;
    logic [1:0] sub_clock_div_o;
    int         err_count, check_count, n;
    int         cycles = 0;

    low_power_mode_control #(.WAIT0(W0), .WAIT1(W1), .WAIT2(W2), .WAIT3(W3), .WAIT4(W4)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sleep_exec_i(sleep_exec_i),
        .watch_clock_on_i(watch_clock_on_i), .wake_pin_i(wake_pin_i),
        .cpu_clk_sub_o(cpu_clk_sub_o), .cpu_stop_o(cpu_stop_o), .clocks_off_o(clocks_off_o),
        .mode_o(mode_o), .noise_sample_tick_o(noise_sample_tick_o),
        .direct_transfer_on_o(direct_transfer_on_o), .medium_speed_select_o(medium_speed_select_o),
        .sub_clock_div_o(sub_clock_div_o));

    // =========================================================================
    // Clock and hang guard; a hung run counts as a mismatch.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            close_out();
        end
    end

    // =========================================================================
    // Shared helpers.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic do_sleep();
        @(posedge clk_i);
        sleep_exec_i <= 1'b1;
        @(posedge clk_i);
        sleep_exec_i <= 1'b0;
        #1;
    endtask

    // Waits a bounded time for the given mode to show.
    task automatic wait_mode(input logic [2:0] m);
        n = 0;
        while (mode_o !== m && n < 40) begin
            tick(1);
            n = n + 1;
        end
        check({5'h0, mode_o}, {5'h0, m});
    endtask

    // Raises the wake pin, counts the settle cycles when a wait is expected, drops the pin.
    task automatic wake(input logic [2:0] m, input int unsigned settle);
        wake_pin_i <= 1'b1;
        if (settle != 0) begin
            wait_mode(lpm_pkg::MODE_SETTLE);
            check({7'h0, clocks_off_o}, 8'h00);
            n = 1;
            tick(1);
            while (mode_o === lpm_pkg::MODE_SETTLE && n < 100) begin
                n = n + 1;
                tick(1);
            end
            check(8'(n), 8'(settle));
        end
        wait_mode(m);
        check({7'h0, cpu_stop_o}, 8'h00);
        wake_pin_i <= 1'b0;
        tick(10);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // =========================================================================
    // Main sequence.
    int unsigned codes [6] = '{0, 1, 2, 3, 4, 7};
    int unsigned waits [6] = '{W0, W1, W2, W3, W4, W4};

    initial begin
        err_count = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        {wr_i, rd_i, sleep_exec_i, watch_clock_on_i, wake_pin_i} = 5'h0;
        addr_i = 2'h0;
        wdata_i = 8'h00;
        tick(4);
        rst_n_i <= 1'b1;
        tick(3);

        // Reset views, unmapped index, read-only status.
        reg_rd(2'h0, 8'h07);
        reg_rd(2'h1, 8'he0);
        reg_rd(2'h2, 8'h00);
        reg_wr(2'h3, 8'hff);
        reg_wr(2'h2, 8'h07);
        reg_rd(2'h3, 8'h00);
        reg_rd(2'h2, 8'h00);
        $display("test reset_and_map done");

        // CPU clock source follows the low-speed bit.
        reg_wr(2'h0, 8'h08);
        tick(2);
        check({7'h0, cpu_clk_sub_o}, 8'h01);
        check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_SUBACTIVE});
        reg_wr(2'h0, 8'h00);
        tick(2);
        check({7'h0, cpu_clk_sub_o}, 8'h00);
        $display("test clock_select done");

        // Noise filter tick spacing for both rate selects, with stored fields.
        for (int s = 0; s < 2; s++) begin
            reg_wr(2'h1, {3'h0, s[0], 4'hf});
            reg_rd(2'h1, {3'h7, s[0], 4'hf});
            check({4'h0, direct_transfer_on_o, medium_speed_select_o, sub_clock_div_o}, 8'h0f);
            n = 0;
            while (noise_sample_tick_o !== 1'b1 && n < 40) begin
                tick(1);
                n = n + 1;
            end
            n = 1;
            tick(1);
            while (noise_sample_tick_o !== 1'b1 && n < 40) begin
                n = n + 1;
                tick(1);
            end
            check(8'(n), (s == 0) ? 8'h10 : 8'h04);
        end
        $display("test noise_rate done");

        // Plain sleep from active and from subactive.
        do_sleep();
        check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_SLEEP});
        check({6'h0, cpu_stop_o, clocks_off_o}, 8'h02);
        wake(lpm_pkg::MODE_ACTIVE, 0);
        reg_wr(2'h0, 8'h08);
        tick(2);
        do_sleep();
        check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_SUBSLEEP});
        wake(lpm_pkg::MODE_SUBACTIVE, 0);
        $display("test plain_sleep done");

        // Standby from active for wait codes 0 to 4 and 7, then watch from active and subactive.
        for (int i = 0; i < 6; i++) begin
            reg_wr(2'h0, {1'b1, 3'(codes[i]), 4'h0});
            tick(2);
            do_sleep();
            check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_STANDBY});
            check({7'h0, clocks_off_o}, 8'h01);
            wake(lpm_pkg::MODE_ACTIVE, waits[i]);
        end
        reg_rd(2'h0, 8'hf7);
        watch_clock_on_i <= 1'b1;
        do_sleep();
        check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_WATCH});
        wake(lpm_pkg::MODE_ACTIVE, W4);
        watch_clock_on_i <= 1'b0;
        reg_wr(2'h0, 8'h98);
        tick(2);
        do_sleep();
        check({5'h0, mode_o}, {5'h0, lpm_pkg::MODE_WATCH});
        reg_rd(2'h2, {5'h0, lpm_pkg::MODE_WATCH});
        wake(lpm_pkg::MODE_SUBACTIVE, W1);
        $display("test standby_watch done");

        close_out();
    end
endmodule
